// ### hdl/mdam_defines.vh
`ifndef MDAM_DEFINES_VH
`define MDAM_DEFINES_VH

// Clock and timing
`define MDAM_CLK_HZ          250000000
`define MDAM_SEC_CYCLES      28'd250000000
`define MDAM_AIRFLOW_SEC     8'd40
`define MDAM_THERMO_SEC      8'd10

// Register byte offsets
`define MDAM_CTRL_OFS        12'h000
`define MDAM_THRESH_OFS      12'h004
`define MDAM_SPD_LIMIT_OFS   12'h008
`define MDAM_SPD_TIME_OFS    12'h00c
`define MDAM_STATUS_OFS      12'h010
`define MDAM_IRQ_STAT_OFS    12'h014
`define MDAM_IRQ_CLR_OFS     12'h018
`define MDAM_IRQ_EN_OFS      12'h01c

// Control register fields
`define MDAM_CTRL_AIR_EN     0
`define MDAM_CTRL_THERMO_EN  1
`define MDAM_CTRL_SEL1_LSB   2
`define MDAM_CTRL_SEL2_LSB   4
`define MDAM_CTRL_TYPE1_LSB  8
`define MDAM_CTRL_TYPE2_LSB  12

// Reset values
`define MDAM_CTRL_RST        16'h0000
`define MDAM_THRESH_RST      16'h0000
`define MDAM_SPD_LIMIT_RST   16'h0000
`define MDAM_SPD_TIME_RST    8'h00
`define MDAM_IRQ_EN_RST      5'h00

// Alarm bit positions in the alarm word, and flag bit positions in the status register
`define MDAM_ALM_AIRFLOW     0
`define MDAM_ALM_THERMO      1
`define MDAM_ALM_TEMP        2
`define MDAM_ALM_COMMUT      3
`define MDAM_ALM_SPEED       4
`define MDAM_STAT_ACTIVE     7
`define MDAM_STAT_NO_ALARM   8

// Operating state codes: 0 run, 1 state I, 2 state II, 3..17 = o1..o15
`define MDAM_ST_RUN          5'h00
`define MDAM_ST_II           5'h02
`define MDAM_ST_O6           5'h08

// Selection and sensor type codes
`define MDAM_SEL_THERMO_A    2'h1
`define MDAM_SEL_THERMO_B    2'h3
`define MDAM_TYPE_LINEAR     3'h1
`define MDAM_TYPE_PTC_LO     3'h2
`define MDAM_TYPE_PTC_HI     3'h5

// Thermistor trip temperatures, one per type code 2..5
`define MDAM_PTC_TRIP_2      16'h0064
`define MDAM_PTC_TRIP_3      16'h006e
`define MDAM_PTC_TRIP_4      16'h0078
`define MDAM_PTC_TRIP_5      16'h0082

`endif

// ### hdl/mdam_monitor.v
`timescale 1ns/100ps
`include "mdam_defines.vh"

module mdam_persist (
    input  wire       clk_i,   // System clock
    input  wire       rstn_i,  // Async reset, active low
    input  wire       tick_i,  // One-second enable pulse
    input  wire       arm_i,   // Condition under watch is present
    input  wire [7:0] limit_i, // Seconds the condition must exceed
    output wire       fire_o   // Condition held longer than limit
);
    // Nine bits leave room for limit+1 even at the largest 8-bit limit
    reg [8:0] count;

    // Saturates one past the limit so "longer than" is exact to a second
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count <= 9'h000;
        end else if (!arm_i) begin
            count <= 9'h000;
        end else if (tick_i && (count <= {1'b0, limit_i})) begin
            count <= count + 9'h001;
        end
    end

    assign fire_o = arm_i && (count > {1'b0, limit_i});
endmodule // mdam_persist

module mdam_monitor #(
    parameter [27:0] SEC_CYCLES = `MDAM_SEC_CYCLES
) (
    input  wire        clk_i,        // System clock, 250 MHz
    input  wire        rstn_i,       // Async reset, active low
    input  wire        psel_i,       // APB select
    input  wire        penable_i,    // APB enable
    input  wire        pwrite_i,     // APB write
    input  wire [11:0] paddr_i,      // APB byte address
    input  wire [31:0] pwdata_i,     // APB write data
    output reg  [31:0] prdata_o,     // APB read data
    output wire        pready_o,     // APB ready, always high
    output reg         pslverr_o,    // APB error on unmapped address
    input  wire [4:0]  op_state_i,   // Converter operating state code
    input  wire        airflow_i,    // Air-flow sensor, 0 = no flow
    input  wire        thermostat_i, // Motor thermostat, 0 = tripped
    input  wire [1:0]  contact_i,    // Channel thermostat contacts
    input  wire [15:0] temp_ch1_i,   // Channel 1 temperature
    input  wire [15:0] temp_ch2_i,   // Channel 2 temperature
    input  wire [15:0] speed_a_i,    // Speed monitor quantity A, signed
    input  wire [15:0] speed_b_i,    // Speed monitor quantity B, signed
    input  wire        commut_i,     // Commutation failure event
    input  wire        overcur_i,    // Overcurrent event
    output reg  [4:0]  alarm_o,      // Alarm word
    output reg         alarm_active_flag_o, // Any alarm active
    output reg         no_alarm_flag_o,     // No alarm active
    output wire        irq_o         // Level interrupt
);
    reg  [15:0] ctrl;
    reg  [15:0] temp_alarm_threshold;
    reg  [15:0] speed_mon_limit;
    reg  [7:0]  speed_mon_time;
    reg  [4:0]  irq_stat;
    reg  [4:0]  irq_en;
    reg  [4:0]  alarm_prev;
    reg  [27:0] sec_cnt;
    reg         sec_tick;
    reg  [4:0]  next_alarm;
    reg  [16:0] spd_abs;
    reg  [15:0] ptc_trip1;
    reg  [15:0] ptc_trip2;

    wire        airflow_monitor_enable;
    wire        thermostat_monitor_enable;
    wire [1:0]  thermostat_select_ch1;
    wire [1:0]  thermostat_select_ch2;
    wire [2:0]  temp_sensor_type_ch1;
    wire [2:0]  temp_sensor_type_ch2;
    wire        in_run_states;
    wire        below_o6;
    wire        air_fire;
    wire        thermo_fire;
    wire        speed_fire;
    wire [16:0] spd_diff;
    wire        spd_over;
    wire        wr_en;
    wire        rd_en;
    wire [4:0]  irq_clr;

    assign airflow_monitor_enable    = ctrl[`MDAM_CTRL_AIR_EN];
    assign thermostat_monitor_enable = ctrl[`MDAM_CTRL_THERMO_EN];
    assign thermostat_select_ch1 = ctrl[`MDAM_CTRL_SEL1_LSB +: 2];
    assign thermostat_select_ch2 = ctrl[`MDAM_CTRL_SEL2_LSB +: 2];
    assign temp_sensor_type_ch1  = ctrl[`MDAM_CTRL_TYPE1_LSB +: 3];
    assign temp_sensor_type_ch2  = ctrl[`MDAM_CTRL_TYPE2_LSB +: 3];

    assign in_run_states = (op_state_i <= `MDAM_ST_II);
    assign below_o6      = (op_state_i < `MDAM_ST_O6);

    // One-second enable for all persistence timers
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_cnt  <= 28'h0000000;
            sec_tick <= 1'b0;
        end else if (sec_cnt >= SEC_CYCLES - 28'h0000001) begin
            sec_cnt  <= 28'h0000000;
            sec_tick <= 1'b1;
        end else begin
            sec_cnt  <= sec_cnt + 28'h0000001;
            sec_tick <= 1'b0;
        end
    end

    // Timer is held in reset outside the allowed states, so a stale
    // count cannot fire the instant the state becomes eligible again
    mdam_persist u_air (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .tick_i  (sec_tick),
        .arm_i   (airflow_monitor_enable && !airflow_i && below_o6),
        .limit_i (`MDAM_AIRFLOW_SEC),
        .fire_o  (air_fire)
    );

    mdam_persist u_thermo (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .tick_i  (sec_tick),
        .arm_i   (thermostat_monitor_enable && !thermostat_i),
        .limit_i (`MDAM_THERMO_SEC),
        .fire_o  (thermo_fire)
    );

    // Magnitude of the difference: a drop below and an overshoot both count
    // The extra sign bit keeps a-b from wrapping at the 16-bit extremes
    assign spd_diff = {speed_a_i[15], speed_a_i}
                    - {speed_b_i[15], speed_b_i};

    always @* begin
        if (spd_diff[16]) begin
            spd_abs = 17'h00000 - spd_diff;
        end else begin
            spd_abs = spd_diff;
        end
    end

    assign spd_over = (spd_abs > {1'b0, speed_mon_limit});

    mdam_persist u_speed (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .tick_i  (sec_tick),
        .arm_i   (spd_over && in_run_states),
        .limit_i (speed_mon_time),
        .fire_o  (speed_fire)
    );

    // Trip temperature for the thermistor type selected on each channel
    always @* begin
        case (temp_sensor_type_ch1)
            3'h2: ptc_trip1 = `MDAM_PTC_TRIP_2;
            3'h3: ptc_trip1 = `MDAM_PTC_TRIP_3;
            3'h4: ptc_trip1 = `MDAM_PTC_TRIP_4;
            default: ptc_trip1 = `MDAM_PTC_TRIP_5;
        endcase
        case (temp_sensor_type_ch2)
            3'h2: ptc_trip2 = `MDAM_PTC_TRIP_2;
            3'h3: ptc_trip2 = `MDAM_PTC_TRIP_3;
            3'h4: ptc_trip2 = `MDAM_PTC_TRIP_4;
            default: ptc_trip2 = `MDAM_PTC_TRIP_5;
        endcase
    end

    always @* begin
        next_alarm = 5'h00;
        next_alarm[`MDAM_ALM_AIRFLOW] = air_fire;
        next_alarm[`MDAM_ALM_THERMO]  = thermo_fire;
        // Channel thermostat contacts act with no persistence delay
        if ((thermostat_select_ch1 == `MDAM_SEL_THERMO_A ||
             thermostat_select_ch1 == `MDAM_SEL_THERMO_B) && !contact_i[0])
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        if ((thermostat_select_ch2 == `MDAM_SEL_THERMO_A ||
             thermostat_select_ch2 == `MDAM_SEL_THERMO_B) && !contact_i[1])
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        if (temp_sensor_type_ch1 == `MDAM_TYPE_LINEAR &&
            temp_ch1_i >= temp_alarm_threshold)
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        if (temp_sensor_type_ch2 == `MDAM_TYPE_LINEAR &&
            temp_ch2_i >= temp_alarm_threshold)
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        if (temp_sensor_type_ch1 >= `MDAM_TYPE_PTC_LO &&
            temp_sensor_type_ch1 <= `MDAM_TYPE_PTC_HI &&
            temp_ch1_i >= ptc_trip1)
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        if (temp_sensor_type_ch2 >= `MDAM_TYPE_PTC_LO &&
            temp_sensor_type_ch2 <= `MDAM_TYPE_PTC_HI &&
            temp_ch2_i >= ptc_trip2)
            next_alarm[`MDAM_ALM_TEMP] = 1'b1;
        next_alarm[`MDAM_ALM_COMMUT] = (commut_i || overcur_i)
                                     && in_run_states;
        next_alarm[`MDAM_ALM_SPEED]  = speed_fire;
    end

    // Word and both flags load on the same edge, so a status read never
    // shows a flag that disagrees with the alarm bits
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_o             <= 5'h00;
            alarm_active_flag_o <= 1'b0;
            no_alarm_flag_o     <= 1'b1;
        end else begin
            alarm_o             <= next_alarm;
            alarm_active_flag_o <= |next_alarm;
            no_alarm_flag_o     <= ~|next_alarm;
        end
    end

    // APB slave: zero wait states
    assign pready_o = 1'b1;
    assign wr_en    = psel_i && penable_i && pwrite_i;
    assign rd_en    = psel_i && penable_i && !pwrite_i;
    assign irq_clr  = (wr_en && paddr_i == `MDAM_IRQ_CLR_OFS)
                    ? pwdata_i[4:0] : 5'h00;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl                 <= `MDAM_CTRL_RST;
            temp_alarm_threshold <= `MDAM_THRESH_RST;
            speed_mon_limit      <= `MDAM_SPD_LIMIT_RST;
            speed_mon_time       <= `MDAM_SPD_TIME_RST;
            irq_en               <= `MDAM_IRQ_EN_RST;
        end else if (wr_en) begin
            if (paddr_i == `MDAM_CTRL_OFS) begin
                ctrl <= pwdata_i[15:0];
            end else if (paddr_i == `MDAM_THRESH_OFS) begin
                temp_alarm_threshold <= pwdata_i[15:0];
            end else if (paddr_i == `MDAM_SPD_LIMIT_OFS) begin
                speed_mon_limit <= pwdata_i[15:0];
            end else if (paddr_i == `MDAM_SPD_TIME_OFS) begin
                speed_mon_time <= pwdata_i[7:0];
            end else if (paddr_i == `MDAM_IRQ_EN_OFS) begin
                irq_en <= pwdata_i[4:0];
            end
        end
    end

    // Sticky bits latch alarm onsets; a new onset beats a same-cycle clear
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            alarm_prev <= 5'h00;
            irq_stat   <= 5'h00;
        end else begin
            alarm_prev <= alarm_o;
            irq_stat   <= (irq_stat & ~irq_clr) | (alarm_o & ~alarm_prev);
        end
    end

    // Level output: it stays high until software clears the status bit
    assign irq_o = |(irq_stat & irq_en);

    // Read data is captured in the setup cycle, so the access phase
    // completes at once and pready can stay tied high
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            if (paddr_i == `MDAM_CTRL_OFS) begin
                prdata_o <= {16'h0000, ctrl};
            end else if (paddr_i == `MDAM_THRESH_OFS) begin
                prdata_o <= {16'h0000, temp_alarm_threshold};
            end else if (paddr_i == `MDAM_SPD_LIMIT_OFS) begin
                prdata_o <= {16'h0000, speed_mon_limit};
            end else if (paddr_i == `MDAM_SPD_TIME_OFS) begin
                prdata_o <= {24'h000000, speed_mon_time};
            end else if (paddr_i == `MDAM_STATUS_OFS) begin
                prdata_o <= {23'h000000, no_alarm_flag_o,
                             alarm_active_flag_o, 2'h0, alarm_o};
            end else if (paddr_i == `MDAM_IRQ_STAT_OFS) begin
                prdata_o <= {27'h0000000, irq_stat};
            end else if (paddr_i == `MDAM_IRQ_CLR_OFS) begin
                prdata_o <= 32'h0000_0000;
            end else if (paddr_i == `MDAM_IRQ_EN_OFS) begin
                prdata_o <= {27'h0000000, irq_en};
            end else begin
                pslverr_o <= 1'b1;
            end
        end else if (!rd_en && !wr_en) begin
            pslverr_o <= 1'b0;
        end
    end
endmodule // mdam_monitor

// ### verif/mdam_sensor_model.sv
`timescale 1ns/100ps
module mdam_sensor_model (
    input  wire logic       clk_i,        // System clock
    input  wire logic       air_trip_i,   // Stop the cooling air
    input  wire logic       th_trip_i,    // Open the motor thermostat
    input  wire logic [1:0] ct_trip_i,    // Open a channel contact
    output logic            airflow_o,    // Flow switch, 0 = no flow
    output logic            thermostat_o, // Thermostat, 0 = tripped
    output logic [1:0]      contact_o     // Channel contacts, 0 = tripped
);
    // Contacts rest closed; a trip opens them only at a clock edge
    initial begin
        airflow_o    = 1'b1;
        thermostat_o = 1'b1;
        contact_o    = 2'h3;
    end
    always @(posedge clk_i) begin
        airflow_o    <= ~air_trip_i;
        thermostat_o <= ~th_trip_i;
        contact_o    <= ~ct_trip_i;
    end
endmodule // mdam_sensor_model

// ### verif/mdam_monitor_checker.sv
`timescale 1ns/100ps
module mdam_monitor_checker #(
    parameter [27:0] SEC_CYCLES = 28'd10
) (
    input wire logic       clk_i,               // System clock
    input wire logic       rstn_i,              // Async reset, active low
    input wire logic [4:0] op_state_i,          // Operating state
    input wire logic       airflow_i,           // Air-flow sensor
    input wire logic       thermostat_i,        // Motor thermostat
    input wire logic       commut_i,            // Commutation event
    input wire logic       overcur_i,           // Overcurrent event
    input wire logic [4:0] alarm_o,             // Alarm word
    input wire logic       alarm_active_flag_o, // Any alarm
    input wire logic       no_alarm_flag_o      // No alarm
);
    localparam int unsigned SEC = SEC_CYCLES;
    logic [31:0] air_lo;
    logic [31:0] th_lo;
    // Low-time counters give a lower bound only; tick phase sets the rest
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            air_lo <= 32'h0;
            th_lo  <= 32'h0;
        end else begin
            air_lo <= airflow_i ? 32'h0 : air_lo + 32'h1;
            th_lo  <= thermostat_i ? 32'h0 : th_lo + 32'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_active_flag: assert property (alarm_active_flag_o == |alarm_o)
        else $error("active flag disagrees with alarm word");
    chk_no_alarm: assert property (
        no_alarm_flag_o == (alarm_o == 5'h00))
        else $error("no-alarm flag disagrees with alarm word");
    chk_air_gated: assert property (
        (op_state_i >= 5'h08) [*2] |=> !alarm_o[0])
        else $error("air-flow alarm in a barred state");
    chk_speed_gated: assert property (
        (op_state_i > 5'h02) [*2] |=> !alarm_o[4])
        else $error("speed alarm in a barred state");
    chk_commut_set: assert property ((commut_i || overcur_i) &&
        op_state_i <= 5'h02 |=> alarm_o[3]) else $error("commutation missed");
    chk_commut_clr: assert property (
        !commut_i && !overcur_i |=> !alarm_o[3])
        else $error("commutation alarm without event");
    chk_air_restart: assert property (airflow_i [*2] |=> !alarm_o[0])
        else $error("air-flow alarm with flow present");
    chk_th_restart: assert property (thermostat_i [*2] |=> !alarm_o[1])
        else $error("thermostat alarm with contact closed");
    chk_air_persist: assert property (
        $rose(alarm_o[0]) |-> air_lo >= 40*SEC)
        else $error("air-flow alarm too early");
    chk_th_persist: assert property (
        $rose(alarm_o[1]) |-> th_lo >= 10*SEC)
        else $error("thermostat alarm too early");
    cov_air: cover property ($rose(alarm_o[0]));
    cov_thermo: cover property ($rose(alarm_o[1]));
    cov_speed: cover property ($rose(alarm_o[4]));
endmodule // mdam_monitor_checker

bind mdam_monitor mdam_monitor_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
    .clk_i(clk_i), .rstn_i(rstn_i), .op_state_i(op_state_i),
    .airflow_i(airflow_i), .thermostat_i(thermostat_i),
    .commut_i(commut_i), .overcur_i(overcur_i), .alarm_o(alarm_o),
    .alarm_active_flag_o(alarm_active_flag_o),
    .no_alarm_flag_o(no_alarm_flag_o));

// ### verif/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int S = 10; // Cycles per second, matches SEC_CYCLES below
    logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i, e;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, q;
    logic [4:0]  op_state_i;
    logic [15:0] temp_ch1_i, temp_ch2_i, speed_a_i, speed_b_i;
    logic        commut_i, overcur_i, air_trip, th_trip;
    logic [1:0]  ct_trip;
    wire  [1:0]  contact_i;
    wire         airflow_i, thermostat_i, pready_o, pslverr_o, irq_o;
    wire         alarm_active_flag_o, no_alarm_flag_o;
    wire  [31:0] prdata_o;
    wire  [4:0]  alarm_o;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    // Row: expected alarm, sensor type, temperature (threshold 16'h0050)
    logic [19:0] rows [9] = '{20'h9_0050, 20'h1_004f, 20'ha_0064,
        20'h2_0063, 20'hb_006e, 20'h4_0077, 20'hc_0078, 20'hd_0082,
        20'h0_ffff};

    mdam_sensor_model u_sens (.clk_i(clk_i), .air_trip_i(air_trip),
        .th_trip_i(th_trip), .ct_trip_i(ct_trip), .airflow_o(airflow_i),
        .thermostat_o(thermostat_i), .contact_o(contact_i));
    mdam_monitor #(.SEC_CYCLES(28'd10)) dut (.clk_i(clk_i),
        .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .op_state_i(op_state_i), .airflow_i(airflow_i),
        .thermostat_i(thermostat_i), .contact_i(contact_i),
        .temp_ch1_i(temp_ch1_i), .temp_ch2_i(temp_ch2_i),
        .speed_a_i(speed_a_i), .speed_b_i(speed_b_i), .commut_i(commut_i),
        .overcur_i(overcur_i), .alarm_o(alarm_o),
        .alarm_active_flag_o(alarm_active_flag_o),
        .no_alarm_flag_o(no_alarm_flag_o), .irq_o(irq_o));

    task automatic results;
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Called just after a rising edge; returns one edge after the access
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0; penable_i <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clk_i);
    endtask
    task automatic wait_alarm(input int b, input int lo, input int hi);
        int n;
        n = 0;
        while (alarm_o[b] !== 1'b1 && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        chk(n >= lo && n <= hi, 1);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, commut_i, overcur_i} <= '0;
        {air_trip, th_trip, ct_trip, paddr_i, pwdata_i} <= '0;
        {temp_ch1_i, temp_ch2_i, speed_a_i, speed_b_i, op_state_i} <= '0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        apb(1, 12'h004, 32'h50);
        for (int i = 0; i < 9; i++) begin
            apb(1, 12'h000, {21'h0, rows[i][18:16], 8'h0});
            temp_ch1_i <= rows[i][15:0];
            repeat (3) @(posedge clk_i);
            apb(0, 12'h010, 0);
            chk(q, rows[i][19] ? 32'h84 : 32'h100);
        end
        temp_ch1_i <= 16'h0;
        for (int k = 0; k < 8; k++) begin
            apb(1, 12'h000, k[2] ? {k[1:0], 4'h0} : {k[1:0], 2'h0});
            ct_trip <= k[2] ? 2'h2 : 2'h1;
            repeat (4) @(posedge clk_i);
            chk(alarm_o[2], k[0]);
            ct_trip <= 2'h0;
            repeat (4) @(posedge clk_i);
        end
        apb(1, 12'h000, 32'h2);
        op_state_i <= 5'h11;
        th_trip <= 1'b1;
        repeat (7 * S) @(posedge clk_i);
        th_trip <= 1'b0;
        repeat (2) @(posedge clk_i);
        th_trip <= 1'b1;
        wait_alarm(1, 10 * S, 11 * S + 6);
        apb(1, 12'h01c, 32'h2);
        @(posedge clk_i);
        chk(irq_o, 1);
        th_trip <= 1'b0;
        apb(1, 12'h018, 32'h2);
        @(posedge clk_i);
        chk(irq_o, 0);
        apb(1, 12'h000, 32'h1);
        op_state_i <= 5'h08;
        air_trip <= 1'b1;
        repeat (45 * S) @(posedge clk_i);
        chk(alarm_o[0], 0);
        op_state_i <= 5'h07;
        wait_alarm(0, 40 * S, 41 * S + 6);
        air_trip <= 1'b0;
        apb(1, 12'h008, 32'h10);
        apb(1, 12'h00c, 32'h2);
        op_state_i <= 5'h01;
        speed_a_i <= 16'h0010;
        repeat (4 * S) @(posedge clk_i);
        chk(alarm_o[4], 0);
        {op_state_i, speed_a_i, speed_b_i} <= {5'h03, 16'h0, 16'h0020};
        repeat (4 * S) @(posedge clk_i);
        chk(alarm_o[4], 0);
        op_state_i <= 5'h00;
        wait_alarm(4, 2 * S, 3 * S + 6);
        {op_state_i, speed_b_i, commut_i} <= {5'h03, 16'h0, 1'b1};
        repeat (3) @(posedge clk_i);
        chk(alarm_o[3], 0);
        for (int v = 0; v < 3; v++) begin
            {op_state_i, commut_i, overcur_i} <= {v[4:0], v[0], ~v[0]};
            repeat (3) @(posedge clk_i);
            chk(alarm_o[3], 1);
        end
        chk(irq_o, 0);
        apb(1, 12'h01c, 32'ha);
        @(posedge clk_i);
        chk(irq_o, 1);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({alarm_o, alarm_active_flag_o, no_alarm_flag_o, irq_o}, 32'h2);
        rstn_i <= 1'b1;
        {commut_i, overcur_i} <= 2'h0;
        @(posedge clk_i);
        apb(0, 12'h000, 0);
        chk(q, 32'h0);
        apb(0, 12'h020, 0);
        chk(q, 32'h0);
        chk(e, 1);
        chk(pready_o, 1);
        results();
    end
endmodule // tb
